/* pkg/pdt_pkg.sv */
// Constants, field positions and states for the PHY diagnostic/test register bank
package pdt_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [9:0] IDX_PHY_STATUS = 10'h010;
   localparam logic [9:0] IDX_TBT = 10'h01a;
   localparam logic [9:0] IDX_BIST1 = 10'h01b;
   localparam logic [9:0] IDX_BIST2 = 10'h01c;
   localparam logic [9:0] IDX_CDIAG = 10'h01e;
   localparam logic [9:0] IDX_RSTCTL = 10'h01f;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h020;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h021;
   localparam logic [9:0] IDX_MISC = 10'h022;
   // Field positions
   localparam int TBT_LOWTH = 13;
   localparam int TBT_SQ_LO = 9;
   localparam int TBT_NLP = 7;
   localparam int TBT_POL = 4;
   localparam int TBT_JAB = 0;
   localparam int PSTS_POL = 12;
   localparam int BIST1_LOCK = 15;
   localparam int BIST1_CNT_LO = 8;
   localparam int CD_START = 15;
   localparam int CD_RESCAL = 14;
   localparam int CD_DONE = 1;
   localparam int CD_FAIL = 0;
   localparam int RST_HARD = 15;
   localparam int RST_SOFT = 14;
   localparam int MISC_WRAP = 0;
   // Interrupt status and mask bits
   localparam int IRQ_POL = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_FAIL = 2;
   localparam int IRQ_SAT = 3;
   localparam int IRQ_W = 4;
   // Widths and reset values
   localparam int SQ_W = 4;
   localparam int GAP_W = 8;
   localparam int LEN_W = 11;
   localparam int CNT_W = 8;
   localparam int IPG_W = 10;
   localparam logic [GAP_W-1:0] BIST_GAP_RST = 8'h7d;
   localparam logic [LEN_W-1:0] BIST_LEN_RST = 11'h5ee;
   localparam logic [15:0] CD_RSV_VAL = 16'h0100;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam int IPG_SHIFT = 2;
   typedef enum logic [1:0] {APB_IDLE = 2'b00, APB_ANS = 2'b01} pdt_apb_st_t;
   typedef enum logic [1:0] {CD_IDLE = 2'b00, CD_RUN = 2'b01} pdt_cd_st_t;
endpackage

/* pkg/pdt_sub_if.sv */
// Signals between the register bank and its counter and cable-diagnostic helpers
`timescale 1ns/10ps
`default_nettype none
interface pdt_sub_if;
   logic clr;
   logic err_pulse;
   logic wrap;
   logic lock;
   logic [7:0] locked;
   logic sat_evt;
   logic start_wr;
   logic abort;
   logic done_in;
   logic fail_in;
   logic run;
   logic done;
   logic fail;
   logic done_evt;
   logic fail_evt;
   modport main (output clr, err_pulse, wrap, lock, start_wr, abort, done_in, fail_in,
      input locked, sat_evt, run, done, fail, done_evt, fail_evt);
   modport cnt (input clr, err_pulse, wrap, lock, output locked, sat_evt);
   modport diag (input clr, start_wr, abort, done_in, fail_in,
      output run, done, fail, done_evt, fail_evt);
endinterface
`default_nettype wire

/* src/pdt_err_counter.sv */
// PRBS errored-byte counter with lock-and-clear capture
`timescale 1ns/10ps
`default_nettype none
module pdt_err_counter (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Link to register bank
   pdt_sub_if.cnt sub
);
   typedef struct packed {
      logic [pdt_pkg::CNT_W-1:0] run;
      logic [pdt_pkg::CNT_W-1:0] locked;
      logic sat_evt;
   } pdt_cnt_st_t;
   pdt_cnt_st_t s;
   pdt_cnt_st_t next_s;

   always_comb begin
      logic [pdt_pkg::CNT_W-1:0] base;
      base = '0;
      next_s = s;
      base = sub.lock ? '0 : s.run;
      next_s.run = base;
      if (sub.lock) begin
         next_s.locked = s.run;
      end
      // An error in the lock cycle counts into the fresh count
      if (sub.err_pulse) begin
         if (base == pdt_pkg::CNT_MAX && !sub.wrap) begin
            next_s.run = base;
         end else begin
            next_s.run = base + 1'b1;
         end
      end
      next_s.sat_evt = (next_s.run == pdt_pkg::CNT_MAX) && (s.run != pdt_pkg::CNT_MAX);
      if (sub.clr) begin
         next_s = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign sub.locked = s.locked;
   assign sub.sat_evt = s.sat_evt;
endmodule
`default_nettype wire

/* src/pdt_cable_diag.sv */
// Cable diagnostic start/done/fail sequencing
`timescale 1ns/10ps
`default_nettype none
module pdt_cable_diag (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Link to register bank
   pdt_sub_if.diag sub
);
   typedef struct packed {
      pdt_pkg::pdt_cd_st_t st;
      logic done;
      logic fail;
      logic done_evt;
      logic fail_evt;
   } pdt_cd_state_t;
   pdt_cd_state_t s;
   pdt_cd_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.done_evt = 1'b0;
      next_s.fail_evt = 1'b0;
      case (s.st)
         pdt_pkg::CD_IDLE: begin
            if (sub.start_wr) begin
               next_s.st = pdt_pkg::CD_RUN;
               next_s.done = 1'b0;
               next_s.fail = 1'b0;
            end
         end
         pdt_pkg::CD_RUN: begin
            if (sub.done_in) begin
               // Start falls in the same edge that done rises
               next_s.st = pdt_pkg::CD_IDLE;
               next_s.done = 1'b1;
               next_s.fail = sub.fail_in;
               next_s.done_evt = 1'b1;
               next_s.fail_evt = sub.fail_in;
            end else if (sub.abort) begin
               next_s.st = pdt_pkg::CD_IDLE;
            end
         end
         default: begin
            next_s.st = pdt_pkg::CD_IDLE;
         end
      endcase
      if (sub.clr) begin
         next_s = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign sub.run = (s.st == pdt_pkg::CD_RUN);
   assign sub.done = s.done;
   assign sub.fail = s.fail;
   assign sub.done_evt = s.done_evt;
   assign sub.fail_evt = s.fail_evt;
endmodule
`default_nettype wire

/* src/pdt_regs.sv */
// APB register bank for 10BASE-T tuning, self-test, cable diagnostic and software reset
//
// How it works
// - Bit 13 lowers 10BASE-T receive threshold.
// - Bits 12-9 pick squelch, 200mV plus 50mV/step.
// - Bit 7 stops normal link pulses.
// - Bit 4 mirrors polarity bit 12 of status.
// - Control read clears polarity; status read doesn't.
// - Bit 0 disables jabber, 10BASE-Te only.
// - Bits 15-8 count PRBS errored bytes.
// - Writing bit 15 locks count, clears counter.
// - Bits 7-0 set packet gap, times four.
// - Bits 10-0 set self-test packet length.
// - Bit 15 starts cable test, self-clears on done.
// - Bit 1 reads one when test done.
// - Bit 0 reads one when test failed.
// - Bit 15 resets everything like reset pin.
// - Bit 14 restarts circuitry, keeps registers.
`timescale 1ns/10ps
`default_nettype none
module pdt_regs (
   // Clock, enable and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver and test status
   input wire logic pol_inverted,
   input wire logic prbs_byte_err,
   input wire logic link_is_10m,
   input wire logic [15:0] phy_status_in,
   input wire logic cable_done_in,
   input wire logic cable_fail_in,
   // Analog and test controls
   output logic lower_threshold_en,
   output logic [3:0] squelch_code,
   output logic nlp_tx_disable,
   output logic jabber_disable,
   output logic [9:0] bist_ipg_bytes,
   output logic [10:0] bist_pkt_len,
   output logic cable_diag_run,
   output logic rescal_en,
   // Reset requests and interrupt
   output logic hard_reset_pulse,
   output logic restart_pulse,
   output logic irq
);
   typedef struct packed {
      pdt_pkg::pdt_apb_st_t apb_st;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic lowth;
      logic [pdt_pkg::SQ_W-1:0] sq;
      logic nlp;
      logic jab;
      logic jab_eff;
      logic pol;
      logic [pdt_pkg::GAP_W-1:0] gap;
      logic [pdt_pkg::IPG_W-1:0] ipg;
      logic [pdt_pkg::LEN_W-1:0] len;
      logic rescal;
      logic rst_hard;
      logic rst_soft;
      logic wrap;
      logic lock;
      logic start_wr;
      logic abort;
      logic [pdt_pkg::IRQ_W-1:0] irq_stat;
      logic [pdt_pkg::IRQ_W-1:0] irq_mask;
      logic irq;
   } pdt_state_t;

   pdt_state_t s;
   pdt_state_t next_s;
   pdt_sub_if sub ();
   logic [pdt_pkg::IRQ_W-1:0] irq_set;
   logic [pdt_pkg::IRQ_W-1:0] irq_w1c;
   logic [pdt_pkg::IRQ_W-1:0] next_irq_stat;

   // Same values after the pin and after a software hard reset
   function automatic pdt_state_t reset_state();
      pdt_state_t r;
      r = '0;
      r.apb_st = pdt_pkg::APB_IDLE;
      r.gap = pdt_pkg::BIST_GAP_RST;
      r.ipg = pdt_pkg::IPG_W'(pdt_pkg::BIST_GAP_RST) << pdt_pkg::IPG_SHIFT;
      r.len = pdt_pkg::BIST_LEN_RST;
      return r;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
      return (a[11:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return hit(a, pdt_pkg::IDX_PHY_STATUS) || hit(a, pdt_pkg::IDX_TBT) ||
         hit(a, pdt_pkg::IDX_BIST1) || hit(a, pdt_pkg::IDX_BIST2) ||
         hit(a, pdt_pkg::IDX_CDIAG) || hit(a, pdt_pkg::IDX_RSTCTL) ||
         hit(a, pdt_pkg::IDX_IRQ_STAT) || hit(a, pdt_pkg::IDX_IRQ_MASK) ||
         hit(a, pdt_pkg::IDX_MISC);
   endfunction

   // Helpers
   pdt_err_counter u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sub(sub.cnt)
   );

   pdt_cable_diag u_diag (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sub(sub.diag)
   );

   assign sub.clr = s.rst_hard;
   assign sub.err_pulse = prbs_byte_err;
   assign sub.wrap = s.wrap;
   assign sub.lock = s.lock;
   assign sub.start_wr = s.start_wr;
   assign sub.abort = s.abort;
   assign sub.done_in = cable_done_in;
   assign sub.fail_in = cable_fail_in;

   // Sticky interrupt bits: a new event wins over a write-one-to-clear
   assign irq_set[pdt_pkg::IRQ_POL] = pol_inverted && !s.pol;
   assign irq_set[pdt_pkg::IRQ_DONE] = sub.done_evt;
   assign irq_set[pdt_pkg::IRQ_FAIL] = sub.fail_evt;
   assign irq_set[pdt_pkg::IRQ_SAT] = sub.sat_evt;
   genvar gi;
   generate
      for (gi = 0; gi < pdt_pkg::IRQ_W; gi++) begin : g_irq
         assign next_irq_stat[gi] = irq_set[gi] || (s.irq_stat[gi] && !irq_w1c[gi]);
      end
   endgenerate

   always_comb begin
      logic access;
      logic done_wr;
      logic [15:0] rd;
      logic [15:0] w;
      access = psel && penable;
      done_wr = 1'b0;
      rd = '0;
      w = pwdata[15:0];
      irq_w1c = '0;
      next_s = s;
      next_s.lock = 1'b0;
      next_s.start_wr = 1'b0;
      next_s.abort = 1'b0;
      next_s.rst_hard = 1'b0;
      next_s.rst_soft = 1'b0;
      // Polarity flag follows the receiver and holds until the 10BASE-T register is read
      if (pol_inverted) begin
         next_s.pol = 1'b1;
      end
      case (s.apb_st)
         pdt_pkg::APB_IDLE: begin
            if (access) begin
               // Reserved bits are left at zero here; the cable register adds its constant
               if (hit(paddr, pdt_pkg::IDX_PHY_STATUS)) begin
                  rd = phy_status_in;
                  rd[pdt_pkg::PSTS_POL] = s.pol;
               end
               if (hit(paddr, pdt_pkg::IDX_TBT)) begin
                  rd[pdt_pkg::TBT_LOWTH] = s.lowth;
                  rd[pdt_pkg::TBT_SQ_LO +: pdt_pkg::SQ_W] = s.sq;
                  rd[pdt_pkg::TBT_NLP] = s.nlp;
                  rd[pdt_pkg::TBT_POL] = s.pol;
                  rd[pdt_pkg::TBT_JAB] = s.jab;
                  if (!pwrite) begin
                     // Set wins: a still-inverted receiver keeps the flag
                     next_s.pol = pol_inverted;
                  end
               end
               if (hit(paddr, pdt_pkg::IDX_BIST1)) begin
                  rd = {sub.locked, s.gap};
               end
               if (hit(paddr, pdt_pkg::IDX_BIST2)) begin
                  rd[pdt_pkg::LEN_W-1:0] = s.len;
               end
               if (hit(paddr, pdt_pkg::IDX_CDIAG)) begin
                  rd = pdt_pkg::CD_RSV_VAL;
                  rd[pdt_pkg::CD_START] = sub.run;
                  rd[pdt_pkg::CD_RESCAL] = s.rescal;
                  rd[pdt_pkg::CD_DONE] = sub.done;
                  rd[pdt_pkg::CD_FAIL] = sub.fail;
               end
               if (hit(paddr, pdt_pkg::IDX_RSTCTL)) begin
                  rd[pdt_pkg::RST_HARD] = s.rst_hard;
                  rd[pdt_pkg::RST_SOFT] = s.rst_soft;
               end
               if (hit(paddr, pdt_pkg::IDX_IRQ_STAT)) begin
                  rd[pdt_pkg::IRQ_W-1:0] = s.irq_stat;
               end
               if (hit(paddr, pdt_pkg::IDX_IRQ_MASK)) begin
                  rd[pdt_pkg::IRQ_W-1:0] = s.irq_mask;
               end
               if (hit(paddr, pdt_pkg::IDX_MISC)) begin
                  rd[pdt_pkg::MISC_WRAP] = s.wrap;
               end
               next_s.prdata = {16'h0000, rd};
               next_s.pslverr = !mapped(paddr);
               next_s.pready = 1'b1;
               next_s.apb_st = pdt_pkg::APB_ANS;
            end
         end
         pdt_pkg::APB_ANS: begin
            // Writes land on the edge where pready is seen high
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
            next_s.apb_st = pdt_pkg::APB_IDLE;
            if (access && pwrite) begin
               done_wr = 1'b1;
            end
         end
         default: begin
            next_s.apb_st = pdt_pkg::APB_IDLE;
            next_s.pready = 1'b0;
         end
      endcase
      if (done_wr) begin
         if (hit(paddr, pdt_pkg::IDX_TBT)) begin
            next_s.lowth = w[pdt_pkg::TBT_LOWTH];
            next_s.sq = w[pdt_pkg::TBT_SQ_LO +: pdt_pkg::SQ_W];
            next_s.nlp = w[pdt_pkg::TBT_NLP];
            next_s.jab = w[pdt_pkg::TBT_JAB];
         end
         if (hit(paddr, pdt_pkg::IDX_BIST1)) begin
            next_s.lock = w[pdt_pkg::BIST1_LOCK];
            next_s.gap = w[pdt_pkg::GAP_W-1:0];
         end
         if (hit(paddr, pdt_pkg::IDX_BIST2)) begin
            next_s.len = w[pdt_pkg::LEN_W-1:0];
         end
         if (hit(paddr, pdt_pkg::IDX_CDIAG)) begin
            next_s.start_wr = w[pdt_pkg::CD_START];
            next_s.abort = !w[pdt_pkg::CD_START];
            next_s.rescal = w[pdt_pkg::CD_RESCAL];
         end
         if (hit(paddr, pdt_pkg::IDX_RSTCTL)) begin
            next_s.rst_hard = w[pdt_pkg::RST_HARD];
            next_s.rst_soft = w[pdt_pkg::RST_SOFT];
         end
         if (hit(paddr, pdt_pkg::IDX_IRQ_STAT)) begin
            irq_w1c = w[pdt_pkg::IRQ_W-1:0];
         end
         if (hit(paddr, pdt_pkg::IDX_IRQ_MASK)) begin
            next_s.irq_mask = w[pdt_pkg::IRQ_W-1:0];
         end
         if (hit(paddr, pdt_pkg::IDX_MISC)) begin
            next_s.wrap = w[pdt_pkg::MISC_WRAP];
         end
      end
      next_s.irq_stat = next_irq_stat;
      // Jabber control has no meaning outside 10 Mb/s operation
      next_s.jab_eff = next_s.jab && link_is_10m;
      next_s.ipg = pdt_pkg::IPG_W'(next_s.gap) << pdt_pkg::IPG_SHIFT;
      // A hard reset must not wipe its own pulse, or the PHY core never sees it
      if (s.rst_hard) begin
         next_s = reset_state();
      end
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= reset_state();
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Outputs straight from state flops; cable_diag_run is decoded from the diagnostic state
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign lower_threshold_en = s.lowth;
   assign squelch_code = s.sq;
   assign nlp_tx_disable = s.nlp;
   assign jabber_disable = s.jab_eff;
   assign bist_ipg_bytes = s.ipg;
   assign bist_pkt_len = s.len;
   assign cable_diag_run = sub.run;
   assign rescal_en = s.rescal;
   assign hard_reset_pulse = s.rst_hard;
   assign restart_pulse = s.rst_soft;
   assign irq = s.irq;
endmodule
`default_nettype wire

/* tb/pdt_regs_monitor.sv */
// Port-level assertion checker for the register bank
`timescale 1ns/10ps
`default_nettype none
module pdt_regs_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Status and controls
   input wire logic link_is_10m,
   input wire logic cable_done_in,
   input wire logic lower_threshold_en,
   input wire logic [3:0] squelch_code,
   input wire logic nlp_tx_disable,
   input wire logic jabber_disable,
   input wire logic [9:0] bist_ipg_bytes,
   input wire logic [10:0] bist_pkt_len,
   input wire logic cable_diag_run,
   input wire logic hard_reset_pulse,
   input wire logic restart_pulse,
   input wire logic irq
);
   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite && ce;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   tbt_write_a: assert property (wr_done && paddr == 12'h068 |=>
      lower_threshold_en == $past(pwdata[13]) && squelch_code == $past(pwdata[12:9])
      && nlp_tx_disable == $past(pwdata[7])) else $error("10BASE-T controls do not follow write");
   gap_write_a: assert property (wr_done && paddr == 12'h06c |=>
      bist_ipg_bytes == {$past(pwdata[7:0]), 2'b00}) else $error("gap output not four times field");
   len_write_a: assert property (wr_done && paddr == 12'h070 |=>
      bist_pkt_len == $past(pwdata[10:0])) else $error("packet length output wrong");
   diag_start_a: assert property (wr_done && paddr == 12'h078 && pwdata[15] |-> ##2
      cable_diag_run) else $error("cable test did not start");
   diag_stop_a: assert property (ce && cable_diag_run && cable_done_in && !wr_done |=>
      !cable_diag_run) else $error("start bit not cleared on done");
   jab_gate_a: assert property (ce && !link_is_10m |=> !jabber_disable)
      else $error("jabber control active outside 10M");
   hard_reset_a: assert property (hard_reset_pulse |=> !hard_reset_pulse &&
      bist_pkt_len == 11'h5ee && bist_ipg_bytes == 10'h1f4 && !irq && !cable_diag_run)
      else $error("software hard reset incomplete");
   restart_keep_a: assert property (restart_pulse |=> !restart_pulse &&
      $stable(bist_pkt_len) && $stable(squelch_code)) else $error("restart disturbed registers");
   answer_time_a: assert property (psel && penable && !pready && ce |=> pready ##1 !pready)
      else $error("APB answer not one wait state");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("slave error without ready");
   reset_val_a: assert property ($rose(presetn) |-> bist_ipg_bytes == 10'h1f4 &&
      bist_pkt_len == 11'h5ee && !irq) else $error("reset values wrong");
   cover property (hard_reset_pulse);
   cover property (restart_pulse);
   cover property (cable_diag_run && cable_done_in);
   cover property (pslverr);
endmodule
bind pdt_regs pdt_regs_monitor i_mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .link_is_10m(link_is_10m), .cable_done_in(cable_done_in),
   .lower_threshold_en(lower_threshold_en), .squelch_code(squelch_code),
   .nlp_tx_disable(nlp_tx_disable), .jabber_disable(jabber_disable),
   .bist_ipg_bytes(bist_ipg_bytes), .bist_pkt_len(bist_pkt_len), .cable_diag_run(cable_diag_run),
   .hard_reset_pulse(hard_reset_pulse), .restart_pulse(restart_pulse), .irq(irq));
`default_nettype wire

/* tb/pdt_regs_tb_top.sv */
// Self-checking bench for the diagnostic and test register bank
`timescale 1ns/10ps
`default_nettype none
module pdt_regs_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic pol_inverted = 1'b0, prbs_byte_err = 1'b0, link_is_10m = 1'b0;
   logic cable_done_in = 1'b0, cable_fail_in = 1'b0;
   logic [15:0] phy_status_in = 16'h0;
   logic [31:0] prdata;
   logic pready, pslverr, lower_threshold_en, nlp_tx_disable, jabber_disable;
   logic cable_diag_run, rescal_en, hard_reset_pulse, restart_pulse, irq;
   logic [3:0] squelch_code;
   logic [9:0] bist_ipg_bytes;
   logic [10:0] bist_pkt_len;
   logic [15:0] seed = 16'h003c;
   logic [15:0] v;
   logic [7:0] g;
   int n;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;

   always #20 pclk = ~pclk;

   pdt_regs i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pol_inverted(pol_inverted), .prbs_byte_err(prbs_byte_err),
      .link_is_10m(link_is_10m), .phy_status_in(phy_status_in), .cable_done_in(cable_done_in),
      .cable_fail_in(cable_fail_in), .lower_threshold_en(lower_threshold_en),
      .squelch_code(squelch_code), .nlp_tx_disable(nlp_tx_disable), .jabber_disable(jabber_disable),
      .bist_ipg_bytes(bist_ipg_bytes), .bist_pkt_len(bist_pkt_len), .cable_diag_run(cable_diag_run),
      .rescal_en(rescal_en), .hard_reset_pulse(hard_reset_pulse), .restart_pulse(restart_pulse),
      .irq(irq));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Only the writable 10BASE-T bits survive, polarity flag sits in bit 4
   function automatic logic [31:0] tbt_exp(input logic [15:0] d, input logic pol);
      return {16'h0, d & 16'h3e81} | {27'h0, pol, 4'h0};
   endfunction
   function automatic logic [31:0] sts_exp(input logic [15:0] s, input logic pol);
      return {16'h0, s[15:13], pol, s[11:0]};
   endfunction

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // Request held until pready is seen high at a rising edge; no latency assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
         output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic xe = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 16'h0, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask
   task automatic errs(input int k);
      repeat (k) begin
         @(posedge pclk);
         prbs_byte_err <= 1'b1;
      end
      @(posedge pclk);
      prbs_byte_err <= 1'b0;
   endtask

   // A hang costs a mismatch and ends the run
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      tick(4);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({22'h0, bist_ipg_bytes}, 32'h1f4);
      chk({21'h0, bist_pkt_len}, 32'h5ee);
      rd(12'h06c, 32'h007d);
      rd(12'h070, 32'h05ee);
      rd(12'h078, 32'h0100);
      rd(12'h07c, 32'h0);
      rd(12'h068, 32'h0);
      // Every squelch code, random remaining bits and link mode
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         v = {seed[15:13], i[3:0], seed[8:0]};
         link_is_10m <= seed[3];
         wr(12'h068, v);
         tick(2);
         chk({28'h0, squelch_code}, {28'h0, v[12:9]});
         chk({30'h0, lower_threshold_en, nlp_tx_disable}, {30'h0, v[13], v[7]});
         chk({31'h0, jabber_disable}, {31'h0, v[0] & seed[3]});
         rd(12'h068, tbt_exp(v, 1'b0));
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         g = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0];
         wr(12'h06c, {1'b0, seed[14:8], g});
         seed = lfsr(seed);
         wr(12'h070, seed);
         tick(1);
         chk({22'h0, bist_ipg_bytes}, {22'h0, g, 2'b00});
         chk({21'h0, bist_pkt_len}, {21'h0, seed[10:0]});
         rd(12'h06c, {24'h0, g});
         rd(12'h070, {21'h0, seed[10:0]});
      end
      // Error counter: capture, saturate, then wrap mode
      seed = lfsr(seed);
      n = int'(seed[3:0]) + 1;
      errs(n);
      rd(12'h06c, {24'h0, g});
      wr(12'h06c, {8'h80, g});
      rd(12'h06c, {16'h0, n[7:0], g});
      errs(300);
      wr(12'h06c, {8'h80, g});
      rd(12'h06c, {16'h0, 8'hff, g});
      chk({31'h0, irq}, 32'h0);
      rd(12'h080, 32'h8);
      wr(12'h080, 16'h000f);
      rd(12'h080, 32'h0);
      wr(12'h088, 16'h0001);
      wr(12'h06c, {8'h80, g});
      errs(300);
      wr(12'h06c, {8'h80, g});
      rd(12'h06c, {16'h0, 8'h2c, g});
      wr(12'h088, 16'h0000);
      wr(12'h080, 16'h000f);
      // Errors while the clock enable is low must not be counted
      @(posedge pclk);
      ce <= 1'b0;
      errs(4);
      ce <= 1'b1;
      wr(12'h06c, {8'h80, g});
      rd(12'h06c, {24'h0, g});
      // Polarity flag, its two copies and the interrupt path
      phy_status_in <= 16'hb5a3;
      rd(12'h040, sts_exp(16'hb5a3, 1'b0));
      @(posedge pclk);
      pol_inverted <= 1'b1;
      @(posedge pclk);
      pol_inverted <= 1'b0;
      tick(2);
      chk({31'h0, irq}, 32'h0);
      wr(12'h084, 16'h0001);
      tick(3);
      chk({31'h0, irq}, 32'h1);
      rd(12'h040, sts_exp(16'hb5a3, 1'b1));
      rd(12'h040, sts_exp(16'hb5a3, 1'b1));
      rd(12'h068, tbt_exp(v, 1'b1));
      rd(12'h068, tbt_exp(v, 1'b0));
      rd(12'h040, sts_exp(16'hb5a3, 1'b0));
      wr(12'h080, 16'h0001);
      tick(3);
      chk({31'h0, irq}, 32'h0);
      // Cable measurement passing, then failing, then aborted
      wr(12'h084, 16'h0006);
      for (int i = 0; i < 2; i++) begin
         wr(12'h078, 16'h8000);
         tick(2);
         chk({31'h0, cable_diag_run}, 32'h1);
         rd(12'h078, 32'h8100);
         @(posedge pclk);
         cable_done_in <= 1'b1;
         cable_fail_in <= i[0];
         @(posedge pclk);
         cable_done_in <= 1'b0;
         cable_fail_in <= ~i[0];
         tick(3);
         chk({30'h0, cable_diag_run, irq}, 32'h1);
         rd(12'h078, {30'h40, 1'b1, i[0]});
         wr(12'h080, 16'h0006);
      end
      wr(12'h078, 16'h8000);
      wr(12'h078, 16'h4000);
      tick(2);
      chk({30'h0, cable_diag_run, rescal_en}, 32'h1);
      rd(12'h078, 32'h4100);
      wr(12'h078, 16'h0000);
      rd(12'h0c4, 32'h0, 1'b1);
      rd(12'h069, 32'h0, 1'b1);
      // Restart keeps registers, hard reset restores them
      wr(12'h070, 16'h0123);
      wr(12'h07c, 16'h4000);
      @(posedge pclk);
      chk({31'h0, restart_pulse}, 32'h1);
      rd(12'h07c, 32'h0);
      rd(12'h070, 32'h0123);
      wr(12'h084, 16'h000f);
      wr(12'h07c, 16'h8000);
      @(posedge pclk);
      chk({31'h0, hard_reset_pulse}, 32'h1);
      tick(2);
      rd(12'h070, 32'h05ee);
      rd(12'h084, 32'h0);
      rd(12'h068, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
